// ==== gpfs_regs.svh ====
// Register offsets, field positions and reset values of the pin function select block.
// Assumes one register word per offset; each port occupies one stride of addresses.
// Notes on behaviour
// R1: Digital enable clear with analog select set hands the pin to analog input.
// R2: Analog pins reach analog circuitry only through a gated isolation switch.
// R3: Alternate peripheral drives pin only with alternate and digital enable; code picks peripheral.
// R4: Every pin has its own selection bits; no pin follows another.
// R5: Ordinary pins reset to plain I/O, tri-stated, pulls off, code zero.
// R6: Power-on or external reset restores every pin's defaults.
// R7: Port A bits 1:0 serial, 5:2 synchronous serial; alternate, digital on, code 0x1.
// R8: Port C bits 3:0 debug: alternate, digital, pull-up on, code 0x3.
// R9: Port C bits 0..3 carry TCK, TMS, TDI, TDO; also SWCLK, SWDIO, SWO.
// R10: Without alternate select the pin follows data and direction logic; code ignored. A pin handed to analog input (R1) is held undriven instead.
`ifndef GPFS_REGS_SVH
`define GPFS_REGS_SVH
`define GPFS_OFF_ALT 5'h00
`define GPFS_OFF_DIG_EN 5'h04
`define GPFS_OFF_ANA_SEL 5'h08
`define GPFS_OFF_PU 5'h0C
`define GPFS_OFF_PD 5'h10
`define GPFS_OFF_PCTL 5'h14
`define GPFS_OFF_STAT 5'h18
`define GPFS_PORT_LSB 5
`define GPFS_PORT_A 3'h0
`define GPFS_PORT_C 3'h2
`define GPFS_RST_A_ALT 8'h3F
`define GPFS_RST_A_PCTL 32'h00111111
`define GPFS_RST_C_ALT 8'h0F
`define GPFS_RST_C_PCTL 32'h00003333
`define GPFS_CODE_DEBUG 4'h3
`define GPFS_PIN_TCK 16
`define GPFS_PIN_TDO 19
`endif

// ==== gpfs_pkg.sv ====
// Types shared by the pin function select block.
// Assumes the constants header is included by users of offsets.
package gpfs_pkg;
  localparam int GPFS_MAX_PORTS = 5;
  localparam int GPFS_PINS = GPFS_MAX_PORTS * 8;

  typedef struct packed {
    logic [7:0] alt;
    logic [7:0] dig_en;
    logic [7:0] ana_sel;
    logic [7:0] pu;
    logic [7:0] pd;
    logic [31:0] pctl;
  } gpfs_port_cfg_t;

  typedef struct packed {
    logic [GPFS_PINS-1:0] out;
    logic [GPFS_PINS-1:0] oe;
    logic [GPFS_PINS-1:0] pu;
    logic [GPFS_PINS-1:0] pd;
  } gpfs_pad_t;

  typedef struct packed {
    gpfs_port_cfg_t [GPFS_MAX_PORTS-1:0] cfg;
    logic [GPFS_PINS-1:0] sync1;
    logic [GPFS_PINS-1:0] sync2;
    gpfs_pad_t pad;
    logic [GPFS_PINS-1:0] ana_conn;
    logic [GPFS_PINS-1:0] gpio_in;
    logic [GPFS_PINS-1:0] alt_in;
    logic [31:0] rdata;
    logic fresh;
  } gpfs_state_t;
endpackage : gpfs_pkg

// ==== gpfs_top.sv ====
// Pin function selection for all general-purpose ports: plain I/O, analog or alternate.
// Assumes pad inputs are asynchronous, data/direction and peripherals share clk.
`include "gpfs_regs.svh"
module gpfs_top #(
  parameter int NPORTS = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic [gpfs_pkg::GPFS_PINS-1:0] gpio_out,
  input wire logic [gpfs_pkg::GPFS_PINS-1:0] gpio_oe,
  input wire logic [gpfs_pkg::GPFS_PINS-1:0][15:0] alt_out,
  input wire logic [gpfs_pkg::GPFS_PINS-1:0][15:0] alt_oe,
  input wire logic [gpfs_pkg::GPFS_PINS-1:0] pad_in,
  output gpfs_pkg::gpfs_pad_t pad,
  output logic [gpfs_pkg::GPFS_PINS-1:0] analog_iso_on,
  output logic [gpfs_pkg::GPFS_PINS-1:0] gpio_in,
  output logic [gpfs_pkg::GPFS_PINS-1:0] alt_in
);
  import gpfs_pkg::*;

  if (NPORTS < 3 || NPORTS > GPFS_MAX_PORTS) begin : g_chk
    $error("NPORTS must lie between 3 and 5");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset image of one port

  function automatic gpfs_port_cfg_t rst_cfg(input int unsigned idx);
    gpfs_port_cfg_t c;
    c = '0;
    if (idx == int'(`GPFS_PORT_A)) begin
      c.alt = `GPFS_RST_A_ALT; // R7
      c.dig_en = `GPFS_RST_A_ALT; // R7
      c.pctl = `GPFS_RST_A_PCTL; // R7
    end else if (idx == int'(`GPFS_PORT_C)) begin
      c.alt = `GPFS_RST_C_ALT; // R8
      c.dig_en = `GPFS_RST_C_ALT; // R8
      c.pu = `GPFS_RST_C_ALT; // R8
      c.pctl = `GPFS_RST_C_PCTL; // R8
    end
    return c;
  endfunction : rst_cfg

  function automatic gpfs_state_t rst_state();
    gpfs_state_t s;
    s = '0;
    for (int i = 0; i < GPFS_MAX_PORTS; i++) begin
      s.cfg[i] = rst_cfg(i); // R5 R6
    end
    s.fresh = 1'b1;
    return s;
  endfunction : rst_state

  function automatic logic [GPFS_PINS-1:0] flat(input gpfs_port_cfg_t [GPFS_MAX_PORTS-1:0] c,
                                                input int unsigned f);
    logic [GPFS_PINS-1:0] v;
    v = '0;
    for (int i = 0; i < GPFS_MAX_PORTS; i++) begin
      case (f)
        0: v[i*8 +: 8] = c[i].alt;
        1: v[i*8 +: 8] = c[i].dig_en;
        2: v[i*8 +: 8] = c[i].ana_sel;
        3: v[i*8 +: 8] = c[i].pu;
        default: v[i*8 +: 8] = c[i].pd;
      endcase
    end
    return v;
  endfunction : flat

  function automatic logic [3:0] code_of(input gpfs_port_cfg_t [GPFS_MAX_PORTS-1:0] c,
                                         input int unsigned p);
    return c[p/8].pctl[(p%8)*4 +: 4];
  endfunction : code_of

  ////////////////////////////////////////////////////////////////////////////////
  // State

  gpfs_state_t s_q;
  gpfs_state_t s_d;

  logic [2:0] port_sel;
  logic [4:0] reg_off;
  assign port_sel = addr[7:`GPFS_PORT_LSB];
  assign reg_off = addr[4:0];

  logic [GPFS_PINS-1:0] alt_v;
  logic [GPFS_PINS-1:0] dig_en_v;
  logic [GPFS_PINS-1:0] ams_v;
  assign alt_v = flat(s_q.cfg, 0);
  assign dig_en_v = flat(s_q.cfg, 1);
  assign ams_v = flat(s_q.cfg, 2);

  always_comb begin
    logic [3:0] code;
    logic ana;
    logic [7:0] bitv;
    code = '0;
    ana = 1'b0;
    bitv = '0;
    s_d = s_q;
    s_d.fresh = 1'b0;
    // Writes land in at most one port's register, so pins of other ports never move with it
    if (wr_en && int'(port_sel) < NPORTS) begin
      case (reg_off)
        `GPFS_OFF_ALT: s_d.cfg[port_sel].alt = wdata[7:0]; // R4
        `GPFS_OFF_DIG_EN: s_d.cfg[port_sel].dig_en = wdata[7:0]; // R4
        `GPFS_OFF_ANA_SEL: s_d.cfg[port_sel].ana_sel = wdata[7:0]; // R4
        `GPFS_OFF_PU: s_d.cfg[port_sel].pu = wdata[7:0];
        `GPFS_OFF_PD: s_d.cfg[port_sel].pd = wdata[7:0];
        `GPFS_OFF_PCTL: s_d.cfg[port_sel].pctl = wdata; // R4
        default: ;
      endcase
    end
    // Read data live only in the cycle after the strobe
    s_d.rdata = '0;
    if (rd_en && int'(port_sel) < NPORTS) begin
      for (int b = 0; b < 8; b++) begin
        bitv[b] = ~s_q.cfg[port_sel].dig_en[b] & s_q.cfg[port_sel].ana_sel[b];
      end
      case (reg_off)
        `GPFS_OFF_ALT: s_d.rdata = {24'h000000, s_q.cfg[port_sel].alt};
        `GPFS_OFF_DIG_EN: s_d.rdata = {24'h000000, s_q.cfg[port_sel].dig_en};
        `GPFS_OFF_ANA_SEL: s_d.rdata = {24'h000000, s_q.cfg[port_sel].ana_sel};
        `GPFS_OFF_PU: s_d.rdata = {24'h000000, s_q.cfg[port_sel].pu};
        `GPFS_OFF_PD: s_d.rdata = {24'h000000, s_q.cfg[port_sel].pd};
        `GPFS_OFF_PCTL: s_d.rdata = s_q.cfg[port_sel].pctl;
        `GPFS_OFF_STAT: s_d.rdata = {16'h0000, s_q.ana_conn[port_sel*8 +: 8], bitv};
        default: s_d.rdata = '0;
      endcase
    end
    // Pad inputs are asynchronous; the first stage feeds only the second
    s_d.sync1 = pad_in;
    s_d.sync2 = s_q.sync1;
    for (int p = 0; p < GPFS_PINS; p++) begin
      code = code_of(s_q.cfg, p);
      ana = ~dig_en_v[p] & ams_v[p]; // R1
      s_d.ana_conn[p] = ana; // R2
      s_d.gpio_in[p] = s_q.sync2[p] & dig_en_v[p];
      s_d.alt_in[p] = s_q.sync2[p] & dig_en_v[p] & alt_v[p]; // R3 R9
      if (ana) begin
        // Digital driver stays off while the analog switch is closed
        s_d.pad.out[p] = 1'b0; // R1
        s_d.pad.oe[p] = 1'b0; // R1
      end else if (alt_v[p] && dig_en_v[p]) begin
        s_d.pad.out[p] = alt_out[p][code]; // R3 R9
        s_d.pad.oe[p] = alt_oe[p][code]; // R3 R9
      end else if (alt_v[p]) begin
        s_d.pad.out[p] = 1'b0; // R3
        s_d.pad.oe[p] = 1'b0; // R3
      end else begin
        s_d.pad.out[p] = gpio_out[p]; // R10
        s_d.pad.oe[p] = gpio_oe[p]; // R10
      end
    end
    s_d.pad.pu = flat(s_q.cfg, 3);
    s_d.pad.pd = flat(s_q.cfg, 4);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= rst_state(); // R6
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign pad = s_q.pad;
  assign analog_iso_on = s_q.ana_conn;
  assign gpio_in = s_q.gpio_in;
  assign alt_in = s_q.alt_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [GPFS_PINS-1:0] plain_v;
  assign plain_v = ~alt_v & ~(~dig_en_v & ams_v);

  // Edges sampled with reset low load the reset image, so path checks skip them
  ana_quiet_a: assert property ((s_q.ana_conn & (s_q.pad.oe | s_q.gpio_in)) == '0) // R1
    else $error("analog pin still driven or read digitally");
  ana_iso_a: assert property (rstn |=> s_q.ana_conn == $past(~dig_en_v & ams_v)) // R2
    else $error("isolation switch does not follow selection");
  rst_dflt_a: assert property (s_q.fresh |-> s_q.cfg[0] == rst_cfg(0)
      && s_q.cfg[1] == '0 && s_q.cfg[2] == rst_cfg(2)) // R6
    else $error("defaults not restored after reset");
  rst_plain_a: assert property (s_q.fresh |-> s_q.cfg[1].alt == 8'h00
      && s_q.cfg[3].dig_en == 8'h00 && s_q.cfg[4].pctl == 32'h00000000) // R5
    else $error("ordinary pin not plain after reset");
  rst_porta_a: assert property (s_q.fresh |-> s_q.cfg[0].pctl[23:0] == 24'h111111
      && s_q.cfg[0].pu == 8'h00) // R7
    else $error("port A serial defaults wrong");
  rst_portc_a: assert property (s_q.fresh |-> s_q.cfg[2].pu[3:0] == 4'hF
      && s_q.cfg[2].pd == 8'h00) // R8
    else $error("port C debug defaults wrong");
  gpio_path_a: assert property (rstn |=> (($past(plain_v) & (s_q.pad.oe ^ $past(gpio_oe))) == '0)
      && (($past(plain_v) & (s_q.pad.out ^ $past(gpio_out))) == '0)) // R10
    else $error("plain pin not following data logic");
  alt_path_a: assert property (rstn && alt_v[`GPFS_PIN_TDO] && dig_en_v[`GPFS_PIN_TDO]
      && !ams_v[`GPFS_PIN_TDO] && code_of(s_q.cfg, `GPFS_PIN_TDO) == `GPFS_CODE_DEBUG
      |=> s_q.pad.out[`GPFS_PIN_TDO] == $past(alt_out[`GPFS_PIN_TDO][3])) // R3 R9
    else $error("debug output not routed from code 3");
  alt_off_a: assert property (rstn |=> (($past(alt_v & ~dig_en_v) & s_q.pad.oe) == '0)) // R3
    else $error("alternate pin driven without digital enable");
  one_port_a: assert property (wr_en && port_sel == 3'h1 && reg_off == `GPFS_OFF_DIG_EN
      |=> s_q.cfg[1].dig_en == $past(wdata[7:0]) && $stable(s_q.cfg[0]) && $stable(s_q.cfg[2])) // R4
    else $error("write touched another port");
  rd_once_a: assert property (!$past(rd_en) |-> s_q.rdata == 32'h00000000)
    else $error("read data outside its cycle");
  tck_sync_a: assert property ((rstn && $stable(dig_en_v[`GPFS_PIN_TCK])) [*3] ##0 dig_en_v[`GPFS_PIN_TCK]
      |=> s_q.gpio_in[`GPFS_PIN_TCK] == $past(pad_in[`GPFS_PIN_TCK], 3)) // R9
    else $error("clock pin input latency wrong");

  ana_cov_c: cover property (s_q.ana_conn != '0);
  alt_cov_c: cover property (wr_en && reg_off == `GPFS_OFF_PCTL ##1 s_q.pad.oe != '0);
  rd_cov_c: cover property (rd_en && reg_off == `GPFS_OFF_STAT ##1 s_q.rdata != '0);
endmodule : gpfs_top

// ==== gpfs_far_model.sv ====
// Far-side model: peripherals feeding the alternate outputs, and the package pins.
// Assumes pad controls come from the pin function select block on the same clock.
module gpfs_far_model (
  input wire logic clk,
  input wire gpfs_pkg::gpfs_pad_t pad,
  output logic [gpfs_pkg::GPFS_PINS-1:0][15:0] alt_out,
  output logic [gpfs_pkg::GPFS_PINS-1:0][15:0] alt_oe,
  output logic [gpfs_pkg::GPFS_PINS-1:0] pad_in
);
  import gpfs_pkg::*;
  logic flip_q = 1'b0;
  always @(posedge clk) flip_q <= ~flip_q;
  always_comb begin
    for (int p = 0; p < GPFS_PINS; p++) begin
      // Level depends on the parity of pin plus code, so a code or pin off by one shows at the pad
      for (int c = 0; c < 16; c++) begin
        alt_out[p][c] = 1'((p + c) % 2);
        alt_oe[p][c] = 1'((p + c + 1) % 2);
      end
      // A floating pin toggles: nothing may rely on a stale level
      if (pad.oe[p]) pad_in[p] = pad.out[p];
      else if (pad.pu[p]) pad_in[p] = 1'b1;
      else if (pad.pd[p]) pad_in[p] = 1'b0;
      else pad_in[p] = flip_q;
    end
  end
endmodule : gpfs_far_model

// ==== testbench.sv ====
// Self-checking bench for the pin function select block.
// Assumes the far-side model supplies peripheral outputs and pad input levels.
`include "gpfs_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpfs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [GPFS_PINS-1:0] gpio_out = '0;
  logic [GPFS_PINS-1:0] gpio_oe = '0;
  logic [GPFS_PINS-1:0][15:0] alt_out;
  logic [GPFS_PINS-1:0][15:0] alt_oe;
  logic [GPFS_PINS-1:0] pad_in;
  logic [GPFS_PINS-1:0] iso_on;
  logic [GPFS_PINS-1:0] gpio_in;
  logic [GPFS_PINS-1:0] alt_in;
  logic [31:0] rdata;
  gpfs_pad_t pad;
  int num_errors = 0;
  int checks_done = 0;
  always #5 clk = ~clk;
  gpfs_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in), .pad(pad),
    .analog_iso_on(iso_on), .gpio_in(gpio_in), .alt_in(alt_in));
  gpfs_far_model far (.clk(clk), .pad(pad), .alt_out(alt_out), .alt_oe(alt_oe),
    .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] port, input logic [4:0] off, input logic [31:0] d);
    @(posedge clk);
    addr <= {port, off};
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] port, input logic [4:0] off, input logic [31:0] e);
    @(posedge clk);
    addr <= {port, off};
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // Pad of pin p while its peripheral of code c owns it
  task automatic pad_chk(input int p, input int c);
    chk({30'h0, pad.oe[p], pad.out[p]}, {30'h0, 1'((p + c + 1) % 2), 1'((p + c) % 2)});
  endtask : pad_chk
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(3'h0, `GPFS_OFF_ALT, 32'h0000003F);
    rd(3'h0, `GPFS_OFF_DIG_EN, 32'h0000003F);
    rd(3'h0, `GPFS_OFF_PU, 32'h00000000);
    rd(3'h0, `GPFS_OFF_PCTL, 32'h00111111);
    rd(3'h2, `GPFS_OFF_PU, 32'h0000000F);
    rd(3'h2, `GPFS_OFF_PD, 32'h00000000);
    rd(3'h2, `GPFS_OFF_PCTL, 32'h00003333);
    rd(3'h1, `GPFS_OFF_ALT, 32'h00000000);
    rd(3'h1, `GPFS_OFF_DIG_EN, 32'h00000000);
    rd(3'h4, `GPFS_OFF_PCTL, 32'h00000000);
    rd(3'h5, `GPFS_OFF_ALT, 32'h00000000);
    chk({24'h0, pad.pu[23:16]}, 32'h0000000F);
    pad_chk(0, 1);
    pad_chk(5, 1);
    pad_chk(16, 3);
    pad_chk(19, 3);
    chk({31'h0, pad.oe[8]}, 32'h0);
    chk({30'h0, alt_in[16], gpio_in[16]}, 32'h00000003);
  endtask : t_defaults
  task automatic t_plain_and_alt;
    @(posedge clk);
    gpio_out[8] <= 1'b1;
    gpio_oe[8] <= 1'b1;
    wr(3'h1, `GPFS_OFF_PCTL, 32'h00000005);
    settle();
    chk({30'h0, pad.oe[8], pad.out[8]}, 32'h00000003);
    wr(3'h1, `GPFS_OFF_ALT, 32'h00000002);
    wr(3'h1, `GPFS_OFF_DIG_EN, 32'h00000003);
    // Every code on pin 9, while pin 8 must keep following the data logic
    for (int c = 0; c < 16; c++) begin
      wr(3'h1, `GPFS_OFF_PCTL, 32'(c) << 4);
      settle();
      pad_chk(9, c);
      chk({30'h0, pad.oe[8], pad.out[8]}, 32'h00000003);
      chk({30'h0, alt_in[8], gpio_in[8]}, 32'h00000001);
    end
  endtask : t_plain_and_alt
  task automatic t_analog;
    wr(3'h1, `GPFS_OFF_ANA_SEL, 32'h00000004);
    settle();
    chk({30'h0, iso_on[10], pad.oe[10]}, 32'h00000002);
    chk({31'h0, iso_on[9]}, 32'h0);
    rd(3'h1, `GPFS_OFF_STAT, 32'h00000404);
    wr(3'h1, `GPFS_OFF_DIG_EN, 32'h00000006);
    settle();
    chk({31'h0, iso_on[10]}, 32'h0);
  endtask : t_analog
  task automatic t_reset_again;
    wr(3'h1, `GPFS_OFF_DIG_EN, 32'h00000002);
    wr(3'h1, `GPFS_OFF_PD, 32'h00000080);
    settle();
    chk({23'h0, iso_on[10], pad.pd[15:8]}, 32'h00000180);
    @(posedge clk);
    rstn <= 1'b0;
    #1 chk({23'h0, iso_on[10], pad.pd[15:8]}, 32'h00000000);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(3'h1, `GPFS_OFF_ANA_SEL, 32'h00000000);
    rd(3'h1, `GPFS_OFF_PCTL, 32'h00000000);
    rd(3'h1, `GPFS_OFF_PD, 32'h00000000);
    rd(3'h2, `GPFS_OFF_ALT, 32'h0000000F);
    chk({24'h0, pad.pu[23:16]}, 32'h0000000F);
  endtask : t_reset_again
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_defaults();
    t_plain_and_alt();
    t_analog();
    t_reset_again();
    close_out();
  end
  // Whole run is well under 1000 cycles
  initial begin
    #50us;
    num_errors++;
    close_out();
  end
endmodule : testbench
